// [core/addr_map_pkg.sv]
// Purpose: shared address map constants for the address space decoder
// Assumes: 12-bit register file and 16-bit program memory addresses
// Notes:   byte-wide data on every path
`default_nettype none

package addr_map_pkg;

    // ========================================================
    // register file space
    localparam int         RF_BYTES   = 4096;
    localparam int         RF_AW      = 12;
    localparam logic [11:0] CTL_BASE  = 12'hf00;
    localparam int         CTL_BYTES  = 256;
    localparam int         RAM_MIN    = 256;
    localparam int         RAM_MAX    = 1024;

    // ========================================================
    // program memory space
    localparam int         PM_AW      = 16;
    localparam int         FLASH_MIN  = 1024;
    localparam int         FLASH_MAX  = 8192;
    localparam logic [7:0] UNIMPL_BYTE = 8'hff;

    // vector layout at the bottom of program memory
    localparam logic [15:0] VEC_RESET = 16'h0002;
    localparam logic [15:0] VEC_WDT   = 16'h0004;
    localparam logic [15:0] VEC_ILL   = 16'h0006;
    localparam logic [15:0] VEC_IRQ   = 16'h0008;
    localparam logic [15:0] VEC_OSC   = 16'h0038;
    localparam logic [15:0] CODE_BASE = 16'h003e;

    // ========================================================
    // information area overlay
    localparam int          INFO_EN_BIT = 7;
    localparam int          INFO_BYTES  = 128;
    localparam logic [15:0] INFO_BASE   = 16'hfe00;
    localparam logic [15:0] INFO_LAST   = 16'hff7f;
    localparam logic [6:0]  OPT_LAST    = 7'h3f;
    localparam logic [6:0]  PART_BASE   = 7'h40;
    localparam int          PART_LEN    = 20;
    localparam logic [7:0]  PART_PAD    = 8'h46;
    localparam logic [6:0]  CAL_BASE    = 7'h60;

    // classification of a program memory access
    typedef enum logic [3:0] {
        PM_OPTION,
        PM_RESET_VEC,
        PM_WDT_VEC,
        PM_ILL_TRAP,
        PM_IRQ_VEC,
        PM_OSC_TRAP,
        PM_CODE,
        PM_UNIMPL,
        PM_INFO
    } pm_region_t;

endpackage

`default_nettype wire

// [core/mem_port_if.sv]
// Purpose: byte-wide single-port memory access bundle
// Assumes: request and answer share one clock
// Notes:   read data is combinational from the storage
`default_nettype none

interface mem_port_if #(parameter int AW = 10);
    logic          req;
    logic          we;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
    logic [7:0]    rdata;

    modport ctrl (output req, we, addr, wdata, input rdata);
    modport mem  (input req, we, addr, wdata, output rdata);
endinterface

`default_nettype wire

// [core/gp_ram.sv]
// Purpose: general-purpose register storage in flip-flops
// Assumes: addresses below BYTES only
// Notes:   write on request edge, read is combinational
`default_nettype none

module gp_ram #(
    parameter int BYTES = 1024
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    mem_port_if.mem   port
);

    typedef struct packed {
        logic [BYTES-1:0][7:0] mem;
    } ram_st_t;

    ram_st_t st_r;
    ram_st_t st_nxt;

    // ========================================================
    // write path
    always_comb
    begin
        st_nxt = st_r;
        if (port.req && port.we)
        begin
            st_nxt.mem[port.addr] = port.wdata;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // read path
    assign port.rdata = st_r.mem[port.addr];

endmodule

`default_nettype wire

// [core/info_rom.sv]
// Purpose: read-only 128-byte information area contents
// Assumes: index is the offset from the overlay base
// Notes:   no write port exists, so contents cannot change
`default_nettype none

module info_rom #(
    parameter logic [511:0] OPTION_BITS = {64{8'hff}},
    // arbitrary neutral identifier, first character in top byte
    parameter logic [159:0] PART_ID     = {"SAMPLE", {14{8'h00}}},
    parameter int           PART_ID_LEN = 6,
    parameter logic [255:0] CAL_DATA    = {32{8'hff}}
) (
    input  wire logic [6:0] idx,
    output logic      [7:0] rdata
);

    generate
        if (PART_ID_LEN < 0 || PART_ID_LEN > addr_map_pkg::PART_LEN)
        begin : g_bad_len
            $error("part identifier longer than its field");
        end
    endgenerate

    logic [6:0] part_k;
    logic [6:0] cal_k;

    assign part_k = idx - addr_map_pkg::PART_BASE;
    assign cal_k  = idx - addr_map_pkg::CAL_BASE;

    // ========================================================
    // byte lookup by field
    always_comb
    begin
        rdata = addr_map_pkg::UNIMPL_BYTE;
        if (idx <= addr_map_pkg::OPT_LAST)
        begin
            rdata = OPTION_BITS[{idx[5:0], 3'b000} +: 8];
        end
        else if (idx >= addr_map_pkg::PART_BASE &&
                 part_k < 7'(addr_map_pkg::PART_LEN))
        begin
            // left-justified, padded with 'F'
            if (part_k < 7'(PART_ID_LEN))
                rdata = PART_ID[8'(8 * (19 - part_k)) +: 8];
            else
                rdata = addr_map_pkg::PART_PAD;
        end
        else if (idx >= addr_map_pkg::CAL_BASE)
        begin
            rdata = CAL_DATA[{cal_k[4:0], 3'b000} +: 8];
        end
    end

endmodule

`default_nettype wire

// [core/address_space_decoder.sv]
// Purpose: decode register file and program memory accesses, data memory never answered
// Assumes: core requests are one-cycle strobes on sys_clk
// Notes:   every register file and program memory request is answered by a one-cycle ack next edge
//
// How it works
// - decode 4096-byte register file space
// - F00H-FFFH go to control registers
// - reserved control reads may return anything
// - RAM contiguous from zero, 256B to 1KB
// - gap reads undefined, gap writes ignored
// - 64KB program space, flash 1KB-8KB backed
// - unimplemented program reads FFH, writes dropped
// - fixed vector layout at program bottom
// - no data memory space responds
// - page select bit 7 enables info area
// - enabled info overlays FE00H-FF7FH reads
// - info area is read-only
// - info holds part identifier and calibration
`default_nettype none

module address_space_decoder #(
    parameter int         RAM_BYTES   = 1024,
    parameter int         FLASH_BYTES = 8192,
    parameter logic [7:0] GAP_BYTE    = 8'h00
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // register file access from the core
    input  wire logic        rf_req,
    input  wire logic        rf_we,
    input  wire logic [11:0] rf_addr,
    input  wire logic [7:0]  rf_wdata,
    output logic             rf_ack,
    output logic      [7:0]  rf_rdata,
    // control register region towards peripherals
    output logic             ctl_sel,
    output logic             ctl_we,
    output logic      [7:0]  ctl_addr,
    output logic      [7:0]  ctl_wdata,
    input  wire logic [7:0]  ctl_rdata,
    // program memory access from the core
    input  wire logic        pm_req,
    input  wire logic        pm_we,
    input  wire logic [15:0] pm_addr,
    input  wire logic [7:0]  pm_wdata,
    output logic             pm_ack,
    output logic      [7:0]  pm_rdata,
    output addr_map_pkg::pm_region_t pm_region,
    // flash array port
    output logic             flash_rd,
    output logic             flash_we,
    output logic      [15:0] flash_addr,
    output logic      [7:0]  flash_wdata,
    input  wire logic [7:0]  flash_rdata,
    // flash page select register value
    input  wire logic [7:0]  flash_page_sel,
    // data memory space
    input  wire logic        dm_req,
    output logic             dm_ack
);

    localparam int RAM_AW = $clog2(RAM_BYTES);

    // ========================================================
    // parameter checks
    generate
        if (RAM_BYTES < addr_map_pkg::RAM_MIN ||
            RAM_BYTES > addr_map_pkg::RAM_MAX ||
            (RAM_BYTES & (RAM_BYTES - 1)) != 0)
        begin : g_bad_ram
            $error("RAM size outside 256 to 1024 power of two");
        end
        if (FLASH_BYTES < addr_map_pkg::FLASH_MIN ||
            FLASH_BYTES > addr_map_pkg::FLASH_MAX)
        begin : g_bad_flash
            $error("flash size outside 1024 to 8192");
        end
    endgenerate

    typedef struct packed {
        logic                     rf_ack;
        logic [7:0]               rf_rdata;
        logic                     pm_ack;
        logic [7:0]               pm_rdata;
        addr_map_pkg::pm_region_t pm_region;
    } dec_st_t;

    dec_st_t st_r;
    dec_st_t st_nxt;

    mem_port_if #(.AW(RAM_AW)) ram_bus ();

    logic       rf_in_ram;
    logic       rf_in_ctl;
    logic       rf_in_gap;
    logic       info_en;
    logic       pm_in_window;
    logic       pm_overlay;
    logic       pm_impl;
    logic [15:0] info_off;
    logic [7:0] info_byte;

    // ========================================================
    // register file decode
    assign rf_in_ram = rf_addr < 12'(RAM_BYTES);
    assign rf_in_ctl = rf_addr >= addr_map_pkg::CTL_BASE;
    assign rf_in_gap = !rf_in_ram && !rf_in_ctl;

    // RAM port, gap addresses never reach it
    assign ram_bus.req   = rf_req && rf_in_ram;
    assign ram_bus.we    = rf_we;
    assign ram_bus.addr  = rf_addr[RAM_AW-1:0];
    assign ram_bus.wdata = rf_wdata;

    // whole control region forwarded, reserved holes included
    assign ctl_sel   = rf_req && rf_in_ctl;
    assign ctl_we    = rf_req && rf_in_ctl && rf_we;
    assign ctl_addr  = rf_addr[7:0];
    assign ctl_wdata = rf_wdata;

    gp_ram #(
        .BYTES (RAM_BYTES)
    ) u_ram (
        .sys_clk (sys_clk),
        .reset   (reset),
        .port    (ram_bus)
    );

    // ========================================================
    // program memory decode
    assign info_en      = flash_page_sel[addr_map_pkg::INFO_EN_BIT];
    assign pm_in_window = pm_addr >= addr_map_pkg::INFO_BASE &&
                          pm_addr <= addr_map_pkg::INFO_LAST;
    assign pm_overlay   = info_en && pm_in_window;
    assign pm_impl      = pm_addr < 16'(FLASH_BYTES);
    assign info_off     = pm_addr - addr_map_pkg::INFO_BASE;

    // flash sees only implemented, non-overlaid addresses
    assign flash_rd    = pm_req && !pm_we && pm_impl && !pm_overlay;
    assign flash_we    = pm_req && pm_we && pm_impl &&
                         !pm_overlay;
    assign flash_addr  = pm_addr;
    assign flash_wdata = pm_wdata;

    info_rom u_info (
        .idx   (info_off[6:0]),
        .rdata (info_byte)
    );

    // region classification of a program address
    function automatic addr_map_pkg::pm_region_t
        classify(input logic [15:0] a, input logic ovl, input logic impl);
        addr_map_pkg::pm_region_t r;
        begin
            if (ovl)
                r = addr_map_pkg::PM_INFO;
            else if (!impl)
                r = addr_map_pkg::PM_UNIMPL;
            else if (a < addr_map_pkg::VEC_RESET)
                r = addr_map_pkg::PM_OPTION;
            else if (a < addr_map_pkg::VEC_WDT)
                r = addr_map_pkg::PM_RESET_VEC;
            else if (a < addr_map_pkg::VEC_ILL)
                r = addr_map_pkg::PM_WDT_VEC;
            else if (a < addr_map_pkg::VEC_IRQ)
                r = addr_map_pkg::PM_ILL_TRAP;
            else if (a < addr_map_pkg::VEC_OSC)
                r = addr_map_pkg::PM_IRQ_VEC;
            else if (a < addr_map_pkg::CODE_BASE)
                r = addr_map_pkg::PM_OSC_TRAP;
            else
                r = addr_map_pkg::PM_CODE;
            return r;
        end
    endfunction

    // ========================================================
    // answer state
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.rf_ack = 1'b0;
        st_nxt.pm_ack = 1'b0;
        if (rf_req)
        begin
            st_nxt.rf_ack = 1'b1;
            if (!rf_we)
            begin
                if (rf_in_ram)
                    st_nxt.rf_rdata = ram_bus.rdata;
                else if (rf_in_ctl)
                    st_nxt.rf_rdata = ctl_rdata;
                else
                    st_nxt.rf_rdata = GAP_BYTE;
            end
        end
        if (pm_req)
        begin
            st_nxt.pm_ack    = 1'b1;
            st_nxt.pm_region = classify(pm_addr, pm_overlay,
                                        pm_impl);
            if (!pm_we)
            begin
                if (pm_overlay)
                    st_nxt.pm_rdata =
                        (info_off < 16'(addr_map_pkg::INFO_BYTES))
                        ? info_byte
                        : addr_map_pkg::UNIMPL_BYTE;
                else if (pm_impl)
                    st_nxt.pm_rdata = flash_rdata;
                else
                    st_nxt.pm_rdata =
                        addr_map_pkg::UNIMPL_BYTE;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rf_ack    = st_r.rf_ack;
    assign rf_rdata  = st_r.rf_rdata;
    assign pm_ack    = st_r.pm_ack;
    assign pm_rdata  = st_r.pm_rdata;
    assign pm_region = st_r.pm_region;

    // data memory space is not decoded, nothing answers
    assign dm_ack = 1'b0;

    // ========================================================
    // assertions
    property p_rf_ack;
        @(posedge sys_clk) disable iff (reset)
        rf_req |=> rf_ack ##1 (rf_ack == $past(rf_req));
    endproperty
    a_rf_ack: assert property (p_rf_ack)
        else $error("register file request not answered");

    property p_ctl_route;
        @(posedge sys_clk) disable iff (reset)
        (rf_req && rf_addr >= 12'hf00) |-> (ctl_sel && !ram_bus.req);
    endproperty
    a_ctl_route: assert property (p_ctl_route)
        else $error("control address not routed to peripherals");

    property p_ctl_read;
        @(posedge sys_clk) disable iff (reset)
        (rf_req && !rf_we && rf_in_ctl)
            |=> (rf_rdata == $past(ctl_rdata));
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("control read data not passed through");

    property p_ram_back;
        @(posedge sys_clk) disable iff (reset)
        (rf_req && !rf_we && rf_in_ram && $past(rf_req && rf_we, 2)
            && !$past(rf_req) && $past(rf_addr, 2) == rf_addr)
            |=> (rf_rdata == $past(rf_wdata, 3));
    endproperty
    a_ram_back: assert property (p_ram_back)
        else $error("RAM read did not return last write");

    property p_gap;
        @(posedge sys_clk) disable iff (reset)
        (rf_req && rf_in_gap) |-> (!ctl_sel && !ram_bus.req);
    endproperty
    a_gap: assert property (p_gap)
        else $error("gap access reached storage");

    property p_flash_read;
        @(posedge sys_clk) disable iff (reset)
        (pm_req && !pm_we && pm_impl && !pm_overlay)
            |-> flash_rd ##1 (pm_rdata == $past(flash_rdata));
    endproperty
    a_flash_read: assert property (p_flash_read)
        else $error("implemented flash read mishandled");

    property p_unimpl;
        @(posedge sys_clk) disable iff (reset)
        (pm_req && !pm_impl && !pm_overlay)
            |-> !flash_we ##1 (pm_ack && (pm_rdata == 8'hff
                || $past(pm_we)));
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented program access mishandled");

    property p_reset_vec;
        @(posedge sys_clk) disable iff (reset)
        (pm_req && pm_addr[15:1] == 15'h0001 && !pm_overlay)
            |=> (pm_region == addr_map_pkg::PM_RESET_VEC);
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset vector misclassified");

    property p_no_data;
        @(posedge sys_clk) disable iff (reset)
        dm_req |-> !dm_ack ##1 !dm_ack;
    endproperty
    a_no_data: assert property (p_no_data)
        else $error("data memory space answered");

    property p_overlay;
        @(posedge sys_clk) disable iff (reset)
        (pm_req && flash_page_sel[7] && pm_addr >= 16'hfe00
            && pm_addr <= 16'hff7f) |-> (!flash_rd && !flash_we);
    endproperty
    a_overlay: assert property (p_overlay)
        else $error("overlaid address reached flash");

    property p_info_ro;
        @(posedge sys_clk) disable iff (reset)
        (pm_req && pm_we && pm_overlay) |-> !flash_we
            ##1 (pm_region == addr_map_pkg::PM_INFO);
    endproperty
    a_info_ro: assert property (p_info_ro)
        else $error("write to information area passed on");

    property p_disabled;
        @(posedge sys_clk) disable iff (reset)
        (pm_req && !pm_we && !info_en && pm_in_window)
            |=> (pm_rdata == ($past(pm_impl) ? $past(flash_rdata)
                                             : 8'hff));
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled overlay read returned info data");

endmodule

`default_nettype wire

// [testbench/flash_periph_model.sv]
// Purpose: flash array and peripheral register stand-in for the decoder
// Assumes: flash read data is combinational while flash_rd is high
// Notes:   released lines show inverted data, never the last value
`default_nettype none

module flash_periph_model (
    input  wire logic        sys_clk,
    input  wire logic        flash_rd,
    input  wire logic        flash_we,
    input  wire logic [15:0] flash_addr,
    input  wire logic [7:0]  flash_wdata,
    output logic      [7:0]  flash_rdata,
    input  wire logic        ctl_sel,
    input  wire logic [7:0]  ctl_addr,
    output logic      [7:0]  ctl_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================
    // storage
    logic [7:0] mem [65536];

    // preload an address-dependent pattern
    initial
    begin
        for (int i = 0; i < 65536; i++)
        begin
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3c;
        end
    end

    // array write on strobe
    always @(posedge sys_clk)
    begin
        if (flash_we)
        begin
            mem[flash_addr] <= flash_wdata;
        end
    end

    // answers only while selected
    assign flash_rdata = flash_rd ? mem[flash_addr] : ~mem[flash_addr];
    assign ctl_rdata   = ctl_sel ? (ctl_addr ^ 8'h96) : ~(ctl_addr ^ 8'h96);
endmodule

`default_nettype wire

// [testbench/tb.sv]
// Purpose: self-checking bench for the address space decoder
// Assumes: one-cycle ack after each taken request
// Notes:   small RAM and flash variants so boundaries are reached
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int RAMB = 512;
    localparam int FLB  = 4096;

    logic        sys_clk, reset;
    logic        rf_req, rf_we, rf_ack, ctl_sel, ctl_we;
    logic [11:0] rf_addr;
    logic [7:0]  rf_wdata, rf_rdata, ctl_addr, ctl_wdata, ctl_rdata;
    logic        pm_req, pm_we, pm_ack, flash_rd, flash_we, dm_req, dm_ack;
    logic [15:0] pm_addr, flash_addr;
    logic [7:0]  pm_wdata, pm_rdata, flash_wdata, flash_rdata, page_sel;
    addr_map_pkg::pm_region_t pm_region;
    logic        seen_sel, seen_we;
    logic [15:0] seen_addr;
    logic [7:0]  seen_data;
    int          n_fail, checks, cycles;

    // ========================================================
    // design and far side
    address_space_decoder #(
        .RAM_BYTES  (RAMB),
        .FLASH_BYTES(FLB),
        .GAP_BYTE   (8'ha5)
    ) dut (
        .sys_clk(sys_clk), .reset(reset),
        .rf_req(rf_req), .rf_we(rf_we), .rf_addr(rf_addr),
        .rf_wdata(rf_wdata), .rf_ack(rf_ack), .rf_rdata(rf_rdata),
        .ctl_sel(ctl_sel), .ctl_we(ctl_we), .ctl_addr(ctl_addr),
        .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
        .pm_req(pm_req), .pm_we(pm_we), .pm_addr(pm_addr),
        .pm_wdata(pm_wdata), .pm_ack(pm_ack), .pm_rdata(pm_rdata),
        .pm_region(pm_region), .flash_rd(flash_rd), .flash_we(flash_we),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_rdata(flash_rdata), .flash_page_sel(page_sel),
        .dm_req(dm_req), .dm_ack(dm_ack)
    );

    flash_periph_model model (
        .sys_clk(sys_clk), .flash_rd(flash_rd), .flash_we(flash_we),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_rdata(flash_rdata), .ctl_sel(ctl_sel),
        .ctl_addr(ctl_addr), .ctl_rdata(ctl_rdata)
    );

    // ========================================================
    // clock and hang guard
    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_fail++;
            finish_test();
        end
    end

    // ========================================================
    // helpers
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one register file access, strobes seen in the request cycle
    task automatic rf_op(input logic we, input logic [11:0] a,
                         input logic [7:0] d);
        @(posedge sys_clk);
        rf_req   <= 1'b1;
        rf_we    <= we;
        rf_addr  <= a;
        rf_wdata <= d;
        #1;
        seen_sel = ctl_sel;
        seen_we  = ctl_we;
        seen_addr = {8'h00, ctl_addr};
        seen_data = ctl_wdata;
        @(posedge sys_clk);
        rf_req <= 1'b0;
        #1;
        chk("rf_ack", 16'h0001, {15'h0000, rf_ack});
    endtask

    task automatic rf_rd(input logic [11:0] a, input logic [7:0] e);
        rf_op(1'b0, a, 8'h00);
        chk("rf_rdata", {8'h00, e}, {8'h00, rf_rdata});
    endtask

    // one program memory access
    task automatic pm_op(input logic we, input logic [15:0] a,
                         input logic [7:0] d);
        @(posedge sys_clk);
        pm_req   <= 1'b1;
        pm_we    <= we;
        pm_addr  <= a;
        pm_wdata <= d;
        #1;
        seen_sel = flash_rd;
        seen_we  = flash_we;
        seen_addr = flash_addr;
        seen_data = flash_wdata;
        @(posedge sys_clk);
        pm_req <= 1'b0;
        #1;
        chk("pm_ack", 16'h0001, {15'h0000, pm_ack});
    endtask

    task automatic pm_rd(input logic [15:0] a, input logic [7:0] e,
                         input logic [3:0] r);
        pm_op(1'b0, a, 8'h00);
        chk("pm_rdata", {8'h00, e}, {8'h00, pm_rdata});
        chk("pm_region", {12'h000, r}, {12'h000, 4'(pm_region)});
    endtask

    // ========================================================
    // scenarios
    task automatic t_ram_gap();
        rf_op(1'b1, 12'h000, 8'h11);
        rf_op(1'b1, 12'h1ff, 8'h22);
        rf_op(1'b1, 12'h200, 8'h99);
        rf_op(1'b1, 12'heff, 8'h77);
        chk("gap_sel", 16'h0000, {15'h0000, seen_sel});
        rf_op(1'b1, 12'h0fe, 8'h5a);
        rf_rd(12'h0fe, 8'h5a);
        rf_rd(12'h000, 8'h11);
        rf_rd(12'h1ff, 8'h22);
        rf_rd(12'h200, 8'ha5);
        rf_rd(12'heff, 8'ha5);
    endtask

    // only the assigned register at f40 is written
    task automatic t_ctl();
        rf_op(1'b1, 12'hf40, 8'h3c);
        chk("ctl_we", 16'h0001, {15'h0000, seen_we});
        chk("ctl_addr", 16'h0040, seen_addr);
        chk("ctl_wdata", 16'h003c, {8'h00, seen_data});
        rf_rd(12'hf00, 8'h96);
        chk("ctl_sel", 16'h0001, {15'h0000, seen_sel});
        rf_rd(12'hf47, 8'hd1);
        rf_rd(12'hfff, 8'h69);
    endtask

    task automatic t_layout();
        logic [15:0] a [12] = '{16'h0001, 16'h0002, 16'h0004, 16'h0007,
            16'h0008, 16'h0037, 16'h0038, 16'h003d, 16'h003e,
            16'h0fff, 16'h1000, 16'hffff};
        logic [47:0] r = 48'h012344556677;
        logic [7:0]  e;
        for (int i = 0; i < 12; i++)
        begin
            e = (i < 10) ? pat(a[i]) : 8'hff;
            pm_rd(a[i], e, r[47-4*i -: 4]);
        end
        pm_op(1'b1, 16'h2000, 8'h55);
        chk("fwe_unimpl", 16'h0000, {15'h0000, seen_we});
        pm_op(1'b1, 16'h0100, 8'h77);
        chk("fwe_code", 16'h0001, {15'h0000, seen_we});
        chk("flash_addr", 16'h0100, seen_addr);
        chk("flash_wdata", 16'h0077, {8'h00, seen_data});
        pm_rd(16'h0100, 8'h77, 4'h6);
        chk("frd_code", 16'h0001, {15'h0000, seen_sel});
    endtask

    task automatic t_info();
        logic [15:0] a [11] = '{16'hfe00, 16'hfe3f, 16'hfe40, 16'hfe45,
            16'hfe46, 16'hfe53, 16'hfe54, 16'hfe60, 16'hfe80, 16'hff7f,
            16'hff80};
        logic [87:0] d = 88'hff_ff_53_45_46_46_ff_ff_ff_ff_ff;
        @(posedge sys_clk);
        page_sel <= 8'h80;
        for (int i = 0; i < 11; i++)
        begin
            pm_rd(a[i], d[87-8*i -: 8], (i < 10) ? 4'h8 : 4'h7);
        end
        pm_op(1'b1, 16'hfe40, 8'h00);
        chk("fwe_info", 16'h0000, {15'h0000, seen_we});
        pm_rd(16'hfe40, 8'h53, 4'h8);
        chk("frd_info", 16'h0000, {15'h0000, seen_sel});
        @(posedge sys_clk);
        page_sel <= 8'h7f;
        pm_rd(16'hfe40, 8'hff, 4'h7);
        pm_rd(16'hfe00, 8'hff, 4'h7);
    endtask

    task automatic t_data_mem();
        @(posedge sys_clk);
        dm_req <= 1'b1;
        repeat (4)
        begin
            @(posedge sys_clk);
            #1;
            chk("dm_ack", 16'h0000, {15'h0000, dm_ack});
        end
        @(posedge sys_clk);
        dm_req <= 1'b0;
    endtask

    // ========================================================
    // main sequence
    initial
    begin
        {reset, rf_req, rf_we, pm_req, pm_we, dm_req} = 6'b100000;
        rf_addr  = 12'h000;
        rf_wdata = 8'h00;
        pm_addr  = 16'h0000;
        pm_wdata = 8'h00;
        page_sel = 8'h00;
        n_fail   = 0;
        checks   = 0;
        cycles   = 0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk("rst_ack", 16'h0000, {14'h0000, rf_ack, pm_ack});
        chk("rst_data", 16'h0000, {rf_rdata, pm_rdata});
        chk("rst_region", 16'h0000, {12'h000, 4'(pm_region)});
        t_ram_gap();
        t_ctl();
        t_layout();
        t_info();
        t_data_mem();
        finish_test();
    end
endmodule

`default_nettype wire
